//--- design/lgu_pkg.sv
// shared constants and types of the scaled base-2 logarithm unit
// assumes an issue stage that presents one operation at a time with its operands
package lgu_pkg;
    // operation codes in the register-operand format
    localparam logic [11:0] OPC_SINGLE = 12'h682;
    localparam logic [11:0] OPC_DOUBLE = 12'h692;
    // fraction bits produced by the logarithm loop, one per cycle
    localparam int FRAC_W = 52;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFF_RES_LO = 8'h0c;
    localparam logic [7:0] OFF_RES_HI = 8'h10;
    // exception flag, status and control bit positions
    localparam int B_OVF = 0;
    localparam int B_UNF = 1;
    localparam int B_INV = 2;
    localparam int B_ZDIV = 3;
    localparam int B_INEX = 4;
    localparam int B_RSV = 5;
    localparam int B_ALIGN = 6;
    localparam int B_NORM = 8;
    localparam int FLAG_W = 5;
    localparam int STAT_W = 7;
    // control reset: all exceptions masked, normalizing mode off
    localparam logic [31:0] CTRL_RST = 32'h0000_001f;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_011f;
    // default encodings
    localparam logic [63:0] QNAN_D = 64'h7ff8_0000_0000_0000;
    localparam logic [63:0] QNAN_S = 64'h0000_0000_7fc0_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        F_NONE, F_RSV, F_ALIGN, F_INV, F_ZDIV, F_OVF, F_UNF, F_INEX
    } lgu_fault_t;

    typedef struct packed {
        logic [11:0] opcode;
        logic [4:0] first_reg;
        logic [4:0] second_reg;
        logic [4:0] dest_reg;
        logic [63:0] first_source;
        logic [63:0] second_source;
    } lgu_issue_t;

    typedef struct packed {
        logic sign;
        logic zero;
        logic inf;
        logic nan;
        logic snan;
        logic denorm;
        logic one;
        logic signed [12:0] exp;
        logic [52:0] mant;
    } lgu_fp_t;
endpackage

//--- design/lgu_unit.sv
// scaled base-2 logarithm unit: result = second_source * log2(first_source)
// assumes synchronous inputs on CLK, single operands in the low 32 bits
`timescale 1ns/100ps
module lgu_unit #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic ISSUE_VALID,
    input wire lgu_pkg::lgu_issue_t ISSUE,
    output logic ISSUE_READY,
    output logic RES_VALID,
    output logic [63:0] RES_DATA,
    output logic [4:0] RES_DEST,
    output logic RES_DOUBLE,
    output logic FAULT_VALID,
    output lgu_pkg::lgu_fault_t FAULT_CODE,
    output logic IRQ,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    typedef enum logic [1:0] {ST_IDLE, ST_DECIDE, ST_LOOP, ST_FINISH} lgu_state_t;

    // split an encoding into class bits, unbiased exponent and 1.52 mantissa
    function automatic lgu_pkg::lgu_fp_t unpack(input logic [63:0] v, input logic dbl);
        lgu_pkg::lgu_fp_t u;
        logic [10:0] ef;
        logic [51:0] fr;
        logic [10:0] top;
        int bias;
        int p;
        u = '0;
        p = 0;
        if (dbl) begin
            ef = v[62:52];
            fr = v[51:0];
            u.sign = v[63];
        end else begin
            ef = {3'h0, v[30:23]};
            fr = {v[22:0], 29'h0};
            u.sign = v[31];
        end
        top = dbl ? 11'h7ff : 11'h0ff;
        bias = dbl ? 1023 : 127;
        u.zero = (ef == 11'h0) && (fr == 52'h0);
        u.denorm = (ef == 11'h0) && (fr != 52'h0);
        u.inf = (ef == top) && (fr == 52'h0);
        u.nan = (ef == top) && (fr != 52'h0);
        u.snan = u.nan && !fr[51];
        u.one = (ef == 11'(bias)) && (fr == 52'h0) && !u.sign;
        u.exp = 13'(int'(ef) - bias);
        u.mant = {1'b1, fr};
        // denormals are renormalised so the loop always starts in [1,2)
        if (u.denorm) begin
            for (int i = 0; i < 52; i++) begin
                if (fr[i]) begin
                    p = i;
                end
            end
            u.mant = 53'({1'b0, fr} << (52 - p));
            u.exp = 13'(1 - bias - 52 + p);
        end
        return u;
    endfunction

    // zero or infinity of the given sign in the selected format
    function automatic logic [63:0] edge_val(input logic s, input logic inf, input logic dbl);
        return dbl ? {s, inf ? 11'h7ff : 11'h0, 52'h0} : {32'h0, s, inf ? 8'hff : 8'h0, 23'h0};
    endfunction

    lgu_state_t state;
    logic [63:0] op1, op2;
    logic dbl_q, odd_q;
    logic [52:0] m;
    logic [51:0] frac;
    logic [5:0] cnt;
    logic [31:0] ctrl_q;
    logic [lgu_pkg::STAT_W-1:0] status_q, irq_mask_q;
    logic [63:0] last_res;

    // issue decode
    wire op_hit = (ISSUE.opcode == lgu_pkg::OPC_SINGLE) || (ISSUE.opcode == lgu_pkg::OPC_DOUBLE);
    wire issue_take = ISSUE_VALID && ISSUE_READY && op_hit;
    wire issue_dbl = (ISSUE.opcode == lgu_pkg::OPC_DOUBLE);
    wire issue_odd = issue_dbl && (ISSUE.first_reg[0] || ISSUE.second_reg[0]
        || ISSUE.dest_reg[0]);

    // operand classes
    lgu_pkg::lgu_fp_t u1, u2;
    assign u1 = unpack(op1, dbl_q);
    assign u2 = unpack(op2, dbl_q);
    wire in_decide = (state == ST_DECIDE);
    wire rsv = ctrl_q[lgu_pkg::B_NORM] && (u1.denorm || u2.denorm);
    wire any_nan = u1.nan || u2.nan;
    wire any_snan = u1.snan || u2.snan;
    wire below_one = u1.exp < 0;
    wire [63:0] qnan = dbl_q ? lgu_pkg::QNAN_D : lgu_pkg::QNAN_S;

    // special operand classes; order follows the exception table
    logic sp;
    logic [63:0] sp_res;
    logic [lgu_pkg::FLAG_W-1:0] sp_flags;
    always_comb begin
        sp = 1'b1;
        sp_res = qnan;
        sp_flags = '0;
        if (any_snan) begin
            sp_flags[lgu_pkg::B_INV] = 1'b1;
        end else if (any_nan) begin
            sp_flags = '0;
        end else if (u1.sign && !u1.zero) begin
            sp_flags[lgu_pkg::B_INV] = 1'b1;
        end else if (u1.zero && u2.zero) begin
            sp_flags[lgu_pkg::B_INV] = 1'b1;
        end else if (u1.zero) begin
            sp_flags[lgu_pkg::B_ZDIV] = 1'b1;
            sp_res = edge_val(!u2.sign, 1'b1, dbl_q);
        end else if (u1.inf && u2.zero) begin
            sp_flags[lgu_pkg::B_INV] = 1'b1;
        end else if (u1.inf) begin
            sp_res = edge_val(u2.sign, 1'b1, dbl_q);
        end else if (u1.one && u2.inf) begin
            sp_flags[lgu_pkg::B_INV] = 1'b1;
        end else if (u1.one) begin
            sp_res = edge_val(u2.sign, 1'b0, dbl_q);
        end else if (u2.zero || u2.inf) begin
            sp_res = edge_val(u2.sign ^ below_one, u2.inf, dbl_q);
        end else begin
            sp = 1'b0;
        end
    end

    // one squaring step: the next fraction bit is whether m*m reached two
    wire [105:0] sq = m * m;
    wire sq_bit = sq[105];
    wire [52:0] next_m = sq_bit ? sq[105:53] : sq[104:52];

    // log as 12.52 two's complement, then normalised and scaled by the second operand
    wire [63:0] lfix = {u1.exp[11:0], frac};
    wire [63:0] labs = lfix[63] ? (~lfix + 64'h1) : lfix;
    logic [5:0] lp;
    always_comb begin
        lp = '0;
        for (int i = 0; i < 64; i++) begin
            if (labs[i]) begin
                lp = 6'(i);
            end
        end
    end
    wire [63:0] lsh = labs << (6'd63 - lp);
    wire [105:0] prod = lsh[63:11] * u2.mant;
    wire [105:0] pnorm = prod[105] ? prod : (prod << 1);
    wire signed [13:0] be = 14'(lp) - 14'sd52 + 14'(u2.exp) + 14'(prod[105])
        + (dbl_q ? 14'sd1023 : 14'sd127);
    wire r_sign = u2.sign ^ lfix[63];

    // rounding is toward zero; any dropped bit or irrational log is inexact
    logic [63:0] gen_res;
    logic [lgu_pkg::FLAG_W-1:0] gen_flags;
    always_comb begin
        gen_flags = '0;
        gen_flags[lgu_pkg::B_INEX] = (|frac) || (|lsh[10:0])
            || (dbl_q ? |pnorm[52:0] : |pnorm[81:0]);
        gen_res = dbl_q ? {r_sign, be[10:0], pnorm[104:53]}
            : {32'h0, r_sign, be[7:0], pnorm[104:82]};
        if (be >= (dbl_q ? 14'sd2047 : 14'sd255)) begin
            gen_flags[lgu_pkg::B_OVF] = 1'b1;
            gen_flags[lgu_pkg::B_INEX] = 1'b1;
            gen_res = edge_val(r_sign, 1'b1, dbl_q);
        end else if (be <= 14'sd0) begin
            // no subnormal output; tiny results flush to zero
            gen_flags[lgu_pkg::B_UNF] = 1'b1;
            gen_flags[lgu_pkg::B_INEX] = 1'b1;
            gen_res = edge_val(r_sign, 1'b0, dbl_q);
        end
    end

    // completion: pick the outcome and turn unmasked flags into a fault
    wire cm_act = (in_decide && (odd_q || rsv || sp)) || (state == ST_FINISH);
    wire [lgu_pkg::FLAG_W-1:0] cm_flags = (odd_q || rsv) ? '0 : (in_decide ? sp_flags : gen_flags);
    wire [63:0] cm_res = in_decide ? sp_res : gen_res;
    wire [lgu_pkg::FLAG_W-1:0] unm = cm_flags & ~ctrl_q[lgu_pkg::FLAG_W-1:0];
    wire lgu_pkg::lgu_fault_t cm_code = odd_q ? lgu_pkg::F_ALIGN
        : rsv ? lgu_pkg::F_RSV
        : unm[lgu_pkg::B_INV] ? lgu_pkg::F_INV
        : unm[lgu_pkg::B_ZDIV] ? lgu_pkg::F_ZDIV
        : unm[lgu_pkg::B_OVF] ? lgu_pkg::F_OVF
        : unm[lgu_pkg::B_UNF] ? lgu_pkg::F_UNF
        : unm[lgu_pkg::B_INEX] ? lgu_pkg::F_INEX : lgu_pkg::F_NONE;
    wire [lgu_pkg::STAT_W-1:0] st_set = cm_act ? {odd_q, rsv && !odd_q, cm_flags} : '0;

    // operation sequencer
    always_ff @(posedge CLK) begin
        RES_VALID <= 1'b0;
        FAULT_VALID <= 1'b0;
        if (SRST) begin
            state <= ST_IDLE;
            ISSUE_READY <= 1'b1;
            RES_DATA <= '0;
            RES_DEST <= '0;
            RES_DOUBLE <= 1'b0;
            FAULT_CODE <= lgu_pkg::F_NONE;
            op1 <= '0;
            op2 <= '0;
            dbl_q <= 1'b0;
            odd_q <= 1'b0;
            m <= '0;
            frac <= '0;
            cnt <= '0;
            last_res <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (issue_take) begin
                        ISSUE_READY <= 1'b0;
                        op1 <= ISSUE.first_source;
                        op2 <= ISSUE.second_source;
                        dbl_q <= issue_dbl;
                        odd_q <= issue_odd;
                        RES_DEST <= ISSUE.dest_reg;
                        RES_DOUBLE <= issue_dbl;
                        state <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    m <= u1.mant;
                    frac <= '0;
                    cnt <= '0;
                    state <= cm_act ? ST_IDLE : ST_LOOP;
                end
                ST_LOOP: begin
                    m <= next_m;
                    frac <= {frac[50:0], sq_bit};
                    cnt <= cnt + 6'd1;
                    if (cnt == 6'(lgu_pkg::FRAC_W - 1)) begin
                        state <= ST_FINISH;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (cm_act) begin
                ISSUE_READY <= 1'b1;
                FAULT_CODE <= cm_code;
                if (cm_code != lgu_pkg::F_NONE) begin
                    FAULT_VALID <= 1'b1; // faulted operations write nothing
                end else begin
                    RES_VALID <= 1'b1;
                    RES_DATA <= cm_res;
                    last_res <= cm_res;
                end
            end
        end
    end

    // register bus: address and data may come in either order
    logic aw_have, w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire wr_do = aw_have && w_have && !S_AXI_BVALID;
    wire [7:0] wa = 8'(aw_addr);
    wire [7:0] ra = 8'(S_AXI_ARADDR);
    wire [31:0] bm = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire wr_ctrl = wr_do && (wa == lgu_pkg::OFF_CTRL);
    wire wr_stat = wr_do && (wa == lgu_pkg::OFF_STATUS);
    wire wr_mask = wr_do && (wa == lgu_pkg::OFF_IRQ_MASK);
    wire wr_ok = wr_ctrl || wr_stat || wr_mask;
    wire [lgu_pkg::STAT_W-1:0] w1c = wr_stat ? lgu_pkg::STAT_W'(w_data & bm) : '0;

    // read decode; unmapped reads give zero and an error response
    logic [31:0] rd_data;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        if (ra == lgu_pkg::OFF_CTRL) begin
            rd_data = ctrl_q;
        end else if (ra == lgu_pkg::OFF_STATUS) begin
            rd_data = 32'(status_q);
        end else if (ra == lgu_pkg::OFF_IRQ_MASK) begin
            rd_data = 32'(irq_mask_q);
        end else if (ra == lgu_pkg::OFF_RES_LO) begin
            rd_data = last_res[31:0];
        end else if (ra == lgu_pkg::OFF_RES_HI) begin
            rd_data = last_res[63:32];
        end else begin
            rd_data = '0;
            rd_ok = 1'b0;
        end
    end

    // bus handshakes and register storage; status set wins over clear
    always_ff @(posedge CLK) begin
        if (SRST) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= lgu_pkg::RESP_OKAY;
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= lgu_pkg::RESP_OKAY;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            ctrl_q <= lgu_pkg::CTRL_RST;
            status_q <= '0;
            irq_mask_q <= '0;
            IRQ <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_do) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? lgu_pkg::RESP_OKAY : lgu_pkg::RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_have <= 1'b0;
                w_have <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_data;
                S_AXI_RRESP <= rd_ok ? lgu_pkg::RESP_OKAY : lgu_pkg::RESP_SLVERR;
            end
            if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
            if (wr_ctrl) begin
                ctrl_q <= ((ctrl_q & ~bm) | (w_data & bm)) & lgu_pkg::CTRL_WMASK;
            end
            if (wr_mask) begin
                irq_mask_q <= lgu_pkg::STAT_W'((32'(irq_mask_q) & ~bm) | (w_data & bm));
            end
            status_q <= (status_q & ~w1c) | st_set;
            IRQ <= |(status_q & irq_mask_q);
        end
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    wire ok_dec = in_decide && !odd_q && !rsv && !any_snan;
    wire inv_mask = ctrl_q[lgu_pkg::B_INV];
    sequence s_done;
        RES_VALID || FAULT_VALID;
    endsequence
    sequence s_odd_take;
        issue_take && issue_odd;
    endsequence
    property p_complete;
        issue_take |-> ##[2:55] s_done;
    endproperty
    a_complete: assert property (p_complete) else $error("operation did not complete");
    property p_align;
        s_odd_take |-> ##2 (FAULT_VALID && FAULT_CODE == lgu_pkg::F_ALIGN);
    endproperty
    a_align: assert property (p_align) else $error("odd register not refused");
    property p_single;
        issue_take && ISSUE.opcode == lgu_pkg::OPC_SINGLE |=> !dbl_q && state == ST_DECIDE;
    endproperty
    a_single: assert property (p_single) else $error("single opcode misdecoded");
    property p_double;
        issue_take && ISSUE.opcode == lgu_pkg::OPC_DOUBLE |=> dbl_q && state == ST_DECIDE;
    endproperty
    a_double: assert property (p_double) else $error("double opcode misdecoded");
    property p_zdiv;
        ok_dec && !any_nan && u1.zero && !u2.zero |=> status_q[lgu_pkg::B_ZDIV];
    endproperty
    a_zdiv: assert property (p_zdiv) else $error("zero-divide not flagged");
    property p_both0;
        ok_dec && !any_nan && u1.zero && u2.zero |=> status_q[lgu_pkg::B_INV];
    endproperty
    a_both0: assert property (p_both0) else $error("zero by zero not invalid");
    property p_neg;
        ok_dec && !any_nan && u1.sign && !u1.zero |=> status_q[lgu_pkg::B_INV];
    endproperty
    a_neg: assert property (p_neg) else $error("negative operand not invalid");
    property p_snan;
        in_decide && !odd_q && !rsv && any_snan |=> status_q[lgu_pkg::B_INV];
    endproperty
    a_snan: assert property (p_snan) else $error("signalling NaN not invalid");
    property p_mask;
        FAULT_VALID && FAULT_CODE == lgu_pkg::F_INV |-> !$past(inv_mask);
    endproperty
    a_mask: assert property (p_mask) else $error("masked exception faulted");
    property p_rsv;
        in_decide && !odd_q && rsv |=> FAULT_VALID && FAULT_CODE == lgu_pkg::F_RSV;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved encoding missed");
    property p_qnan;
        ok_dec && any_nan |=> RES_VALID && !FAULT_VALID && RES_DATA == $past(qnan);
    endproperty
    a_qnan: assert property (p_qnan) else $error("quiet NaN not passed");
endmodule

//--- sim/lgu_issue_model.sv
// issue-side model: offers one operation to the unit, then waits for its completion
// assumes the bench sets op and pulses go for one cycle while the model is idle
`timescale 1ns/100ps
module lgu_issue_model (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic go,
    input wire lgu_pkg::lgu_issue_t op,
    input wire logic ISSUE_READY,
    input wire logic RES_VALID,
    input wire logic FAULT_VALID,
    output logic ISSUE_VALID,
    output lgu_pkg::lgu_issue_t ISSUE,
    output logic done,
    output logic fault_seen
);
    logic busy;
    // request held until taken; payload scrambled after release so nothing stale looks valid
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ISSUE_VALID <= 1'h0;
            ISSUE <= '0;
            busy <= 1'h0;
            done <= 1'h0;
            fault_seen <= 1'h0;
        end else begin
            done <= 1'h0;
            if (go && !ISSUE_VALID && !busy) begin
                ISSUE_VALID <= 1'h1;
                ISSUE <= op; // register indices as the caller chose them
            end else if (ISSUE_VALID && ISSUE_READY) begin
                ISSUE_VALID <= 1'h0;
                ISSUE <= ~ISSUE;
                busy <= 1'h1;
            end else if (busy && (RES_VALID || FAULT_VALID)) begin
                busy <= 1'h0;
                done <= 1'h1;
                fault_seen <= FAULT_VALID;
            end
        end
    end
endmodule

//--- sim/tb_top.sv
// self-checking bench of the scaled logarithm unit
// assumes the issue model on the operand side and an AXI4-Lite master in the bench
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] RG_CTRL = lgu_pkg::OFF_CTRL;
    localparam logic [7:0] RG_STAT = lgu_pkg::OFF_STATUS;
    localparam logic [7:0] RG_MASK = lgu_pkg::OFF_IRQ_MASK;
    localparam logic [1:0] OK = lgu_pkg::RESP_OKAY;
    localparam logic [63:0] D1 = 64'h3ff0_0000_0000_0000;
    localparam logic [63:0] DINF = 64'h7ff0_0000_0000_0000;
    localparam logic [63:0] DNEG2 = 64'hc000_0000_0000_0000;
    localparam logic [63:0] DQN = lgu_pkg::QNAN_D;
    logic CLK;
    logic SRST = 1'h1;
    logic go = 1'h0;
    lgu_pkg::lgu_issue_t op = '0;
    lgu_pkg::lgu_issue_t issue;
    lgu_pkg::lgu_fault_t fault_code;
    logic issue_valid, issue_ready, res_valid, fault_valid, irq, done, fault_seen;
    logic [63:0] res_data;
    logic [4:0] res_dest;
    logic res_double;
    logic [7:0] awaddr = '0;
    logic [7:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;

    initial begin
        CLK = 1'h0;
        forever #25 CLK = ~CLK;
    end

    lgu_unit #(.ADDR_W(8)) lgu_unit_i (.CLK(CLK), .SRST(SRST), .ISSUE_VALID(issue_valid),
        .ISSUE(issue), .ISSUE_READY(issue_ready), .RES_VALID(res_valid), .RES_DATA(res_data),
        .RES_DEST(res_dest), .RES_DOUBLE(res_double), .FAULT_VALID(fault_valid),
        .FAULT_CODE(fault_code),
        .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    lgu_issue_model lgu_issue_model_i (.CLK(CLK), .SRST(SRST), .go(go), .op(op),
        .ISSUE_READY(issue_ready), .RES_VALID(res_valid), .FAULT_VALID(fault_valid),
        .ISSUE_VALID(issue_valid), .ISSUE(issue), .done(done), .fault_seen(fault_seen));

    task automatic summarize;
        $display("compares %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // aw and w offered together, each dropped once its own ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge CLK);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk(64'(bresp), 64'(er));
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge CLK);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'h0;
        chk(64'(rresp), 64'(er));
    endtask

    task automatic op_run(input logic [11:0] opc, input logic [4:0] dr,
                          input logic [63:0] a, input logic [63:0] b);
        @(posedge CLK);
        op <= '{opc, 5'h2, 5'h4, dr, a, b};
        go <= 1'h1;
        @(posedge CLK);
        go <= 1'h0;
        do @(posedge CLK); while (!done);
    endtask

    // masked exceptions: value written, sticky flags checked then cleared
    task automatic run(input logic [11:0] opc, input logic [63:0] a, input logic [63:0] b,
                       input bit ck, input logic [63:0] exp, input logic [31:0] m);
        logic [31:0] st;
        op_run(opc, 5'h6, a, b);
        chk(64'(fault_seen), 64'h0);
        chk(64'(res_dest), 64'h6);
        chk(64'(res_double), 64'(opc == lgu_pkg::OPC_DOUBLE));
        if (ck) chk(res_data, exp);
        rd(RG_STAT, st, OK);
        chk(64'((m == 32'h0) ? st : (st & m)), 64'(m));
        wr(RG_STAT, 32'h7f, OK);
    endtask

    task automatic fop(input logic [4:0] dr, input logic [63:0] a, input lgu_pkg::lgu_fault_t c);
        op_run(lgu_pkg::OPC_DOUBLE, dr, a, D1);
        chk(64'(fault_seen), 64'h1);
        chk(64'(fault_code), 64'(c));
        chk(64'(res_dest), 64'(dr));
    endtask

    task automatic t_regs;
        logic [31:0] v;
        rd(RG_CTRL, v, OK);
        chk(64'(v), 64'(lgu_pkg::CTRL_RST));
        rd(RG_MASK, v, OK);
        chk(64'(v), 64'h0);
        rd(8'h20, v, lgu_pkg::RESP_SLVERR); // unmapped place answers with an error
        chk(64'(v), 64'h0);
        wr(8'h20, 32'h1, lgu_pkg::RESP_SLVERR);
        $display("register test done");
    endtask

    task automatic t_arith;
        logic [31:0] v;
        run(lgu_pkg::OPC_SINGLE, 64'h4100_0000, 64'h4040_0000, 1, 64'h4110_0000, 0);
        run(lgu_pkg::OPC_DOUBLE, 64'h4010_0000_0000_0000, 64'h4004_0000_0000_0000, 1,
            64'h4014_0000_0000_0000, 0);
        // last result readable as two words over the bus
        rd(lgu_pkg::OFF_RES_HI, v, OK);
        chk(64'(v), 64'h4014_0000);
        rd(lgu_pkg::OFF_RES_LO, v, OK);
        chk(64'(v), 64'h0);
        run(lgu_pkg::OPC_SINGLE, 64'h4040_0000, 64'h3f80_0000, 0, 0, 32'h10);
        $display("arithmetic test done");
    endtask

    task automatic t_special;
        run(lgu_pkg::OPC_DOUBLE, 0, D1, 1, 64'hfff0_0000_0000_0000, 32'h8);
        run(lgu_pkg::OPC_DOUBLE, 0, 0, 1, DQN, 32'h4);
        run(lgu_pkg::OPC_DOUBLE, DINF, 0, 1, DQN, 32'h4);
        run(lgu_pkg::OPC_DOUBLE, D1, DINF, 1, DQN, 32'h4);
        run(lgu_pkg::OPC_DOUBLE, DNEG2, D1, 1, DQN, 32'h4);
        run(lgu_pkg::OPC_DOUBLE, 64'h4000_0000_0000_0000, 64'h7ff4_0000_0000_0000, 1, DQN,
            32'h4);
        run(lgu_pkg::OPC_DOUBLE, DQN, D1, 1, DQN, 0);
        $display("special operand test done");
    endtask

    task automatic t_range;
        run(lgu_pkg::OPC_SINGLE, 64'h7180_0000, 64'h7f7f_ffff, 1, 64'h7f80_0000, 32'h1);
        run(lgu_pkg::OPC_SINGLE, 64'h3f80_0001, 64'h0080_0000, 1, 64'h0, 32'h2);
        $display("range test done");
    endtask

    // unmasked invalid faults and drives the interrupt through mask and clear
    task automatic t_faults;
        wr(RG_CTRL, 32'h1b, OK);
        wr(RG_MASK, 32'h4, OK);
        fop(5'h6, DNEG2, lgu_pkg::F_INV);
        repeat (2) @(posedge CLK);
        chk(64'(irq), 64'h1);
        wr(RG_MASK, 32'h0, OK);
        repeat (2) @(posedge CLK);
        chk(64'(irq), 64'h0);
        wr(RG_MASK, 32'h4, OK);
        repeat (2) @(posedge CLK);
        chk(64'(irq), 64'h1);
        wr(RG_STAT, 32'h7f, OK);
        repeat (2) @(posedge CLK);
        chk(64'(irq), 64'h0);
        wr(RG_CTRL, 32'h11f, OK);
        fop(5'h6, 64'h1, lgu_pkg::F_RSV);
        wr(RG_CTRL, 32'h1f, OK);
        fop(5'h3, D1, lgu_pkg::F_ALIGN);
        wr(RG_STAT, 32'h7f, OK);
        $display("fault test done");
    endtask

    // longest op is about 60 cycles; this ceiling leaves wide margin
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize;
        end
    end

    initial begin
        repeat (6) @(posedge CLK);
        SRST <= 1'h0;
        t_regs;
        t_arith;
        t_special;
        t_range;
        t_faults;
        summarize;
    end
endmodule
